// >>> shared/bccr_cfg.svh
// constants for the bridge specific configuration register block
`ifndef BCCR_CFG_SVH
`define BCCR_CFG_SVH

// config space placement, byte offset of the 16-bit word
`define BCCR_OFFS 8'h40
`define BCCR_WIDTH 16

// field positions inside the word
`define BCCR_MODE_HI 15
`define BCCR_MODE_LO 14
`define BCCR_APIC_BIT 13
`define BCCR_FINE_BIT 12
`define BCCR_FREQ_HI 10
`define BCCR_FREQ_LO 9
`define BCCR_PEER_BIT 7
`define BCCR_GPE_BIT 5

// reset values: plain reset word, sticky bit after power reset
`define BCCR_RESET_VAL 16'h0080
`define BCCR_APIC_RESET 1'h1

// writable bits; everything else reads zero
`define BCCR_WR_MASK 16'hF6A0

// writable masks handed to the io base and limit registers
`define BCCR_IO_MASK_COARSE 8'hF0
`define BCCR_IO_MASK_FINE 8'hFC

// mode and frequency codes
`define BCCR_MODE_CONV 2'h0
`define BCCR_MODE_PCIX1 2'h1
`define BCCR_FREQ_33 2'h0
`define BCCR_FREQ_66 2'h1
`define BCCR_FREQ_100 2'h2
`define BCCR_FREQ_133 2'h3

`endif

// >>> shared/bccr_pkg.sv
// types shared by the bridge specific configuration register block
package bccr_pkg;

	// configuration space access, one cycle per request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [1:0] be;
		logic [15:0] wdata;
	} bccr_cfg_req_type;

	// io address presented for window decode
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
	} bccr_io_req_type;

	// memory read arriving on the secondary side
	typedef struct packed {
		logic valid;
		logic peer_hit;
	} bccr_mrd_req_type;

	// hot-plug message state, one-hot
	typedef enum logic [1:0] {
		BCCR_GPE_IDLE = 2'b01,
		BCCR_GPE_ACTIVE = 2'b10
	} bccr_gpe_state_type;

endpackage

// >>> logic/bccr_io_decode.sv
// io window decoder at 4 KB or 1 KB granularity
`timescale 1ns/1ps
`include "bccr_cfg.svh"

module bccr_io_decode (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic fine_en,
	input wire logic [7:0] io_base,
	input wire logic [7:0] io_limit,
	input wire bccr_pkg::bccr_io_req_type io_req,
	output logic io_hit
);

	logic next_io_hit;
	logic [5:0] base6;
	logic [5:0] lim6;

	// coarse mode forces the low pair to the 4 KB block edges
	always_comb begin
		base6 = {io_base[7:4], fine_en ? io_base[3:2] : 2'h0};
		lim6 = {io_limit[7:4], fine_en ? io_limit[3:2] : 2'h3};
		next_io_hit = io_req.valid && (io_req.addr[15:10] >= base6) && (io_req.addr[15:10] <= lim6);
	end

	// registered so the hit lines up with other decode outputs
	always_ff @(posedge mclk) begin
		if (rst) begin
			io_hit <= 1'h0;
		end else if (ce) begin
			io_hit <= next_io_hit;
		end
	end

endmodule

// >>> logic/bccr_top.sv
// bridge specific configuration register and the logic it steers
`timescale 1ns/1ps
`include "bccr_cfg.svh"

// Overview of operation
// - mode bits 15:14: 00 conventional, 01 PCI-X mode 1, others reserved.
// - mode field shows strapped bus mode after power-up; writes change bus mode.
// - hot plug off: requests beyond slot capability fall back to 33 MHz conventional.
// - frequency bits 10:9 select 33, 66, 100 or 133 MHz.
// - bit 13 set master-aborts express config accesses to the interrupt controller.
// - bit 13 leaves SMBus and memory paths alone; sticky, resets to 1.
// - bit 12 makes io base/limit bits 11:10 and 3:2 writable and compared.
// - bit 12 set decodes io at 1 KB, clear keeps 4 KB.
// - bit 7 clear sends every secondary memory read to express.
// - bit 7 set also allows peer-to-peer memory reads.
// - bit 5 set turns hot-plug interrupts into assert/deassert GPE messages.
// - 16-bit word at offsets 40h-41h, reset value 0080h.
module bccr_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic pwr_rst,
	input wire logic ce,
	input wire bccr_pkg::bccr_cfg_req_type cfg_req,
	output logic [15:0] cfg_rdata,
	output logic cfg_rvalid,
	input wire logic [1:0] strap_mode,
	input wire logic hotplug_enable,
	input wire logic [1:0] cap_mode,
	input wire logic [1:0] cap_freq,
	output logic [1:0] sec_bus_mode,
	output logic [1:0] sec_bus_freq,
	input wire logic apic_cfg_req,
	input wire logic apic_smb_req,
	input wire logic apic_mem_req,
	output logic apic_cfg_grant,
	output logic apic_cfg_abort,
	output logic apic_smb_grant,
	output logic apic_mem_grant,
	input wire logic [7:0] io_base,
	input wire logic [7:0] io_limit,
	input wire bccr_pkg::bccr_io_req_type io_req,
	output logic [7:0] io_wmask,
	output logic io_hit,
	input wire bccr_pkg::bccr_mrd_req_type mrd_req,
	output logic mrd_to_pcie,
	output logic mrd_to_peer,
	input wire logic hp_int,
	output logic hp_int_out,
	output logic assert_gpe,
	output logic deassert_gpe
);

	// decide what the secondary bus really runs at
	function automatic logic [3:0] bccr_resolve(
		input logic hp_on,
		input logic [1:0] req_mode,
		input logic [1:0] req_freq,
		input logic [1:0] max_mode,
		input logic [1:0] max_freq
	);
		logic over;
		over = (req_mode > max_mode) || (req_freq > max_freq) || req_mode[1];
		if (!hp_on && over) begin
			bccr_resolve = {`BCCR_MODE_CONV, `BCCR_FREQ_33};
		end else begin
			bccr_resolve = {req_mode, req_freq};
		end
	endfunction

	// merge one write byte lane, keeping only writable bits
	function automatic logic [7:0] bccr_lane(
		input logic en,
		input logic [7:0] old,
		input logic [7:0] data,
		input logic [7:0] mask
	);
		bccr_lane = en ? ((old & ~mask) | (data & mask)) : old;
	endfunction

	// register state
	logic [15:0] cfg_word;
	logic [15:0] next_cfg_word;
	logic apic_blk;
	logic next_apic_blk;
	logic strap_done;
	logic next_strap_done;
	logic [1:0] strap_s1;
	logic [1:0] strap_s2;
	logic [15:0] next_cfg_rdata;
	logic next_cfg_rvalid;
	logic hit;
	logic [15:0] wr_mask;
	logic [15:0] merged;
	logic [15:0] read_word;

	// strap pins come from outside, two flops before use
	always_ff @(posedge mclk) begin
		strap_s1 <= strap_mode;
		strap_s2 <= strap_s1;
	end

	// word decode: offsets 40h and 41h share one access
	always_comb begin
		hit = (cfg_req.addr[7:1] == 7'(`BCCR_OFFS >> 1));
		wr_mask = `BCCR_WR_MASK;
		merged[15:8] = bccr_lane(cfg_req.be[1], cfg_word[15:8], cfg_req.wdata[15:8], wr_mask[15:8]);
		merged[7:0] = bccr_lane(cfg_req.be[0], cfg_word[7:0], cfg_req.wdata[7:0], wr_mask[7:0]);
		read_word = cfg_word & wr_mask;
		read_word[`BCCR_APIC_BIT] = apic_blk;
	end

	// next value of the plain (non sticky) part of the word and of the sticky bit
	always_comb begin
		next_cfg_word = cfg_word;
		next_strap_done = strap_done;
		next_apic_blk = apic_blk;
		if (!strap_done) begin
			// first enabled cycle after reset shows the strapped bus mode
			next_cfg_word[`BCCR_MODE_HI:`BCCR_MODE_LO] = strap_s2;
			next_strap_done = 1'h1;
		end else if (cfg_req.wr && hit) begin
			next_cfg_word = merged;
			if (cfg_req.be[1]) begin
				next_apic_blk = cfg_req.wdata[`BCCR_APIC_BIT];
			end
		end
		next_cfg_word[`BCCR_APIC_BIT] = 1'h0;
	end

	// plain reset clears the word to its default
	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_word <= `BCCR_RESET_VAL;
			strap_done <= 1'h0;
		end else if (ce) begin
			cfg_word <= next_cfg_word;
			strap_done <= next_strap_done;
		end
	end

	// sticky bit survives the plain reset, only power reset sets it
	always_ff @(posedge mclk) begin
		if (pwr_rst) begin
			apic_blk <= `BCCR_APIC_RESET;
		end else if (ce && !rst) begin
			apic_blk <= next_apic_blk;
		end
	end

	// read data, answered one cycle after the request
	always_comb begin
		next_cfg_rvalid = cfg_req.rd;
		next_cfg_rdata = (cfg_req.rd && hit) ? read_word : 16'h0000;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_rdata <= 16'h0000;
			cfg_rvalid <= 1'h0;
		end else if (ce) begin
			cfg_rdata <= next_cfg_rdata;
			cfg_rvalid <= next_cfg_rvalid;
		end
	end

	// effective bus mode and frequency; software must reset the bus itself
	logic [3:0] next_bus;

	always_comb begin
		next_bus = bccr_resolve(hotplug_enable, cfg_word[`BCCR_MODE_HI:`BCCR_MODE_LO],
			cfg_word[`BCCR_FREQ_HI:`BCCR_FREQ_LO], cap_mode, cap_freq);
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sec_bus_mode <= `BCCR_MODE_CONV;
			sec_bus_freq <= `BCCR_FREQ_33;
		end else if (ce) begin
			sec_bus_mode <= next_bus[3:2];
			sec_bus_freq <= next_bus[1:0];
		end
	end

	// interrupt controller access gating
	logic next_apic_grant;
	logic next_apic_abort;

	always_comb begin
		next_apic_grant = apic_cfg_req && !apic_blk;
		next_apic_abort = apic_cfg_req && apic_blk;
	end

	// side paths never look at the block bit
	always_ff @(posedge mclk) begin
		if (rst) begin
			apic_cfg_grant <= 1'h0;
			apic_cfg_abort <= 1'h0;
			apic_smb_grant <= 1'h0;
			apic_mem_grant <= 1'h0;
		end else if (ce) begin
			apic_cfg_grant <= next_apic_grant;
			apic_cfg_abort <= next_apic_abort;
			apic_smb_grant <= apic_smb_req;
			apic_mem_grant <= apic_mem_req;
		end
	end

	// io window: writable mask out to the base/limit registers
	logic [7:0] next_io_wmask;

	always_comb begin
		next_io_wmask = cfg_word[`BCCR_FINE_BIT] ? `BCCR_IO_MASK_FINE : `BCCR_IO_MASK_COARSE;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			io_wmask <= `BCCR_IO_MASK_COARSE;
		end else if (ce) begin
			io_wmask <= next_io_wmask;
		end
	end

	bccr_io_decode u_io_decode (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.fine_en(cfg_word[`BCCR_FINE_BIT]),
		.io_base(io_base),
		.io_limit(io_limit),
		.io_req(io_req),
		.io_hit(io_hit)
	);

	// secondary memory reads; the peer path is correct but slow
	logic next_to_pcie;
	logic next_to_peer;

	always_comb begin
		next_to_peer = mrd_req.valid && cfg_word[`BCCR_PEER_BIT] && mrd_req.peer_hit;
		next_to_pcie = mrd_req.valid && !next_to_peer;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			mrd_to_pcie <= 1'h0;
			mrd_to_peer <= 1'h0;
		end else if (ce) begin
			mrd_to_pcie <= next_to_pcie;
			mrd_to_peer <= next_to_peer;
		end
	end

	// hot-plug interrupt: level out, or a message pair when redirected
	bccr_pkg::bccr_gpe_state_type gpe_state;
	bccr_pkg::bccr_gpe_state_type next_gpe_state;
	logic next_assert;
	logic next_deassert;
	logic next_hp_out;

	always_comb begin
		next_gpe_state = gpe_state;
		next_assert = 1'h0;
		next_deassert = 1'h0;
		next_hp_out = hp_int && !cfg_word[`BCCR_GPE_BIT];
		unique case (gpe_state)
			bccr_pkg::BCCR_GPE_IDLE: begin
				if (hp_int && cfg_word[`BCCR_GPE_BIT]) begin
					next_assert = 1'h1;
					next_gpe_state = bccr_pkg::BCCR_GPE_ACTIVE;
				end
			end
			bccr_pkg::BCCR_GPE_ACTIVE: begin
				// disabling mid-interrupt still closes the message pair
				if (!hp_int || !cfg_word[`BCCR_GPE_BIT]) begin
					next_deassert = 1'h1;
					next_gpe_state = bccr_pkg::BCCR_GPE_IDLE;
				end
			end
			default: begin
				next_gpe_state = bccr_pkg::BCCR_GPE_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			gpe_state <= bccr_pkg::BCCR_GPE_IDLE;
			assert_gpe <= 1'h0;
			deassert_gpe <= 1'h0;
			hp_int_out <= 1'h0;
		end else if (ce) begin
			gpe_state <= next_gpe_state;
			assert_gpe <= next_assert;
			deassert_gpe <= next_deassert;
			hp_int_out <= next_hp_out;
		end
	end

	// checks on the behaviour above
	default clocking bccr_clk @(posedge mclk);
	endclocking
	default disable iff (rst || pwr_rst);

	a_apic_abort_on: assert property (ce && apic_cfg_req && apic_blk |=> apic_cfg_abort && !apic_cfg_grant)
		else $error("blocked controller access not aborted");
	a_apic_open: assert property (ce && apic_cfg_req && !apic_blk |=> apic_cfg_grant && !apic_cfg_abort)
		else $error("open controller access not granted");
	a_side_free: assert property (ce && apic_smb_req && apic_mem_req |=> apic_smb_grant && apic_mem_grant)
		else $error("side path access blocked");
	a_reserved_zero: assert property (cfg_rvalid |-> (cfg_rdata & ~`BCCR_WR_MASK) == 16'h0000)
		else $error("reserved bits read nonzero");
	a_cap_fallback: assert property (ce && !hotplug_enable && strap_done && (cap_freq < cfg_word[10:9]) |=>
		sec_bus_mode == `BCCR_MODE_CONV && sec_bus_freq == `BCCR_FREQ_33)
		else $error("over capability request not aliased to 33 MHz");
	a_freq_follow: assert property (ce && hotplug_enable |=> sec_bus_freq == $past(cfg_word[10:9]))
		else $error("bus frequency does not follow field");
	a_fine_mask: assert property (ce && cfg_word[`BCCR_FINE_BIT] |=> io_wmask == `BCCR_IO_MASK_FINE)
		else $error("fine decode mask not applied");
	a_peer_off: assert property (ce && mrd_req.valid && !cfg_word[`BCCR_PEER_BIT] |=> mrd_to_pcie && !mrd_to_peer)
		else $error("memory read not sent upstream");
	a_peer_on: assert property (ce && mrd_req.valid && mrd_req.peer_hit && cfg_word[`BCCR_PEER_BIT] |=> mrd_to_peer)
		else $error("peer read not taken");

	sequence s_hp_rise;
		ce && gpe_state == bccr_pkg::BCCR_GPE_IDLE && hp_int && cfg_word[`BCCR_GPE_BIT];
	endsequence
	sequence s_msg_out;
		assert_gpe && !hp_int_out;
	endsequence
	a_gpe_msg: assert property (s_hp_rise |=> s_msg_out)
		else $error("hot-plug interrupt not turned into message");
	a_reset_word: assert property (disable iff (1'b0) rst |=> cfg_word == `BCCR_RESET_VAL)
		else $error("reset value wrong");

endmodule

// >>> verification/tb_bccr_top.sv
// self-checking bench for the bridge specific configuration register block
`timescale 1ns/1ps

module tb_bccr_top;
	logic mclk, rst, pwr_rst, ce;
	bccr_pkg::bccr_cfg_req_type cfg_req;
	bccr_pkg::bccr_io_req_type io_req;
	bccr_pkg::bccr_mrd_req_type mrd_req;
	logic [15:0] cfg_rdata, rd;
	logic cfg_rvalid, hotplug_enable, hp_int, hp_int_out, assert_gpe, deassert_gpe;
	logic [1:0] strap_mode, cap_mode, cap_freq, sec_bus_mode, sec_bus_freq;
	logic apic_cfg_req, apic_smb_req, apic_mem_req;
	logic apic_cfg_grant, apic_cfg_abort, apic_smb_grant, apic_mem_grant;
	logic [7:0] io_base, io_limit, io_wmask;
	logic io_hit, mrd_to_pcie, mrd_to_peer;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;

	bccr_top u_dut (.mclk(mclk), .rst(rst), .pwr_rst(pwr_rst), .ce(ce), .cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .strap_mode(strap_mode),
		.hotplug_enable(hotplug_enable), .cap_mode(cap_mode), .cap_freq(cap_freq),
		.sec_bus_mode(sec_bus_mode), .sec_bus_freq(sec_bus_freq), .apic_cfg_req(apic_cfg_req),
		.apic_smb_req(apic_smb_req), .apic_mem_req(apic_mem_req), .apic_cfg_grant(apic_cfg_grant),
		.apic_cfg_abort(apic_cfg_abort), .apic_smb_grant(apic_smb_grant),
		.apic_mem_grant(apic_mem_grant), .io_base(io_base), .io_limit(io_limit), .io_req(io_req),
		.io_wmask(io_wmask), .io_hit(io_hit), .mrd_req(mrd_req), .mrd_to_pcie(mrd_to_pcie),
		.mrd_to_peer(mrd_to_peer), .hp_int(hp_int), .hp_int_out(hp_int_out),
		.assert_gpe(assert_gpe), .deassert_gpe(deassert_gpe));

	// 250 MHz core clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// hang guard, the whole run needs about a hundred cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			complete_run();
		end
	end

	// inputs always move 1 ns after the rising edge
	task automatic step();
		@(posedge mclk);
		#1;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// rst held 5 cycles; two idle edges so the strap load lands first
	task automatic do_reset(input logic pwr);
		rst = 1'b1;
		pwr_rst = pwr;
		repeat (5) @(posedge mclk);
		#1;
		rst = 1'b0;
		pwr_rst = 1'b0;
		step();
		step();
	endtask

	// release then let one edge pass, so no signal moves twice in one step
	task automatic cfg_wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
		cfg_req = '{wr: 1'b1, rd: 1'b0, addr: a, be: b, wdata: d};
		step();
		cfg_req = '0;
		step();
	endtask

	task automatic cfg_rd(input logic [7:0] a, output logic [15:0] d);
		cfg_req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 2'h3, wdata: 16'h0000};
		step();
		check({15'h0000, cfg_rvalid}, 16'h0001);
		d = cfg_rdata;
		cfg_req = '0;
		step();
	endtask

	task automatic t_reset();
		do_reset(1'b1);
		cfg_rd(8'h40, rd);
		check(rd, 16'h6080);
		check({14'h0000, sec_bus_mode}, 16'h0001);
		check({8'h00, io_wmask}, 16'h00F0);
		$display("test reset done");
	endtask

	// reserved bits, unmapped places and byte enables
	task automatic t_mask();
		cfg_wr(8'h40, 2'h3, 16'hFFFF);
		cfg_rd(8'h40, rd);
		check(rd, 16'hF6A0);
		cfg_rd(8'h41, rd);
		check(rd, 16'hF6A0);
		cfg_rd(8'h42, rd);
		check(rd, 16'h0000);
		cfg_wr(8'h44, 2'h3, 16'h0000);
		cfg_wr(8'h40, 2'h1, 16'h0000);
		cfg_rd(8'h40, rd);
		check(rd, 16'hF600);
		check({8'h00, io_wmask}, 16'h00FC);
		$display("test mask done");
	endtask

	// bit 13 survives a plain reset, only power reset sets it
	task automatic t_sticky();
		cfg_wr(8'h40, 2'h3, 16'h0000);
		do_reset(1'b0);
		cfg_rd(8'h40, rd);
		check(rd, 16'h4080);
		do_reset(1'b1);
		cfg_rd(8'h40, rd);
		check(rd, 16'h6080);
		$display("test sticky done");
	endtask

	// caps are set before the fields are written, as software must
	task automatic set_bus(input logic [1:0] m, input logic [1:0] f);
		cfg_wr(8'h40, 2'h3, {m, 3'h0, f, 9'h000});
		step();
	endtask

	task automatic t_freq();
		for (int f = 0; f < 4; f++) begin
			set_bus(2'h1, f[1:0]);
			check({12'h000, sec_bus_mode, sec_bus_freq}, {12'h000, 2'h1, f[1:0]});
		end
		set_bus(2'h0, 2'h2);
		check({12'h000, sec_bus_mode, sec_bus_freq}, 16'h0002);
		cap_freq = 2'h1;
		set_bus(2'h2, 2'h0);
		check({12'h000, sec_bus_mode, sec_bus_freq}, 16'h0000);
		set_bus(2'h1, 2'h3);
		check({12'h000, sec_bus_mode, sec_bus_freq}, 16'h0000);
		// hot plug owns the checks; the field is not written while it is on
		hotplug_enable = 1'b1;
		step();
		check({12'h000, sec_bus_mode, sec_bus_freq}, 16'h0007);
		hotplug_enable = 1'b0;
		cap_freq = 2'h3;
		$display("test freq done");
	endtask

	task automatic apic_probe(input logic [15:0] exp);
		apic_cfg_req = 1'b1;
		apic_smb_req = 1'b1;
		apic_mem_req = 1'b1;
		step();
		check({12'h000, apic_cfg_grant, apic_cfg_abort, apic_smb_grant, apic_mem_grant}, exp);
		apic_cfg_req = 1'b0;
		apic_smb_req = 1'b0;
		apic_mem_req = 1'b0;
		step();
	endtask

	task automatic t_apic();
		cfg_wr(8'h40, 2'h3, 16'h2000);
		apic_probe(16'h0007);
		cfg_wr(8'h40, 2'h3, 16'h0000);
		apic_probe(16'h000B);
		$display("test apic done");
	endtask

	task automatic io_probe(input logic [15:0] a, input logic exp);
		io_req = '{valid: 1'b1, addr: a};
		step();
		check({15'h0000, io_hit}, {15'h0000, exp});
		io_req = '0;
		step();
	endtask

	// 1000h-1FFFh at 4 KB, 1400h-17FFh at 1 KB
	task automatic t_io();
		io_base = 8'h14;
		io_limit = 8'h14;
		io_probe(16'h1C00, 1'b1);
		io_probe(16'h2000, 1'b0);
		cfg_wr(8'h40, 2'h3, 16'h1000);
		io_probe(16'h1C00, 1'b0);
		io_probe(16'h1400, 1'b1);
		io_probe(16'h1800, 1'b0);
		$display("test io done");
	endtask

	task automatic mrd_probe(input logic peer, input logic [15:0] exp);
		mrd_req = '{valid: 1'b1, peer_hit: peer};
		step();
		check({14'h0000, mrd_to_peer, mrd_to_pcie}, exp);
		mrd_req = '0;
		step();
	endtask

	task automatic t_mrd();
		cfg_wr(8'h40, 2'h3, 16'h0080);
		mrd_probe(1'b1, 16'h0002);
		mrd_probe(1'b0, 16'h0001);
		cfg_wr(8'h40, 2'h3, 16'h0000);
		mrd_probe(1'b1, 16'h0001);
		$display("test mrd done");
	endtask

	// clock enable low: a write is not taken and nothing moves
	task automatic t_ce();
		ce = 1'b0;
		cfg_wr(8'h40, 2'h3, 16'h1000);
		ce = 1'b1;
		cfg_rd(8'h40, rd);
		check(rd, 16'h0000);
		check({8'h00, io_wmask}, 16'h00F0);
		$display("test ce done");
	endtask

	task automatic t_gpe();
		cfg_wr(8'h40, 2'h3, 16'h0020);
		hp_int = 1'b1;
		step();
		check({14'h0000, assert_gpe, deassert_gpe}, 16'h0002);
		step();
		check({14'h0000, assert_gpe, deassert_gpe}, 16'h0000);
		hp_int = 1'b0;
		step();
		check({14'h0000, assert_gpe, deassert_gpe}, 16'h0001);
		// with redirection off the interrupt line is passed on instead
		cfg_wr(8'h40, 2'h3, 16'h0000);
		hp_int = 1'b1;
		step();
		check({15'h0000, hp_int_out}, 16'h0001);
		hp_int = 1'b0;
		step();
		$display("test gpe done");
	endtask

	initial begin
		rst = 1'b1;
		pwr_rst = 1'b1;
		ce = 1'b1;
		cfg_req = '0;
		io_req = '0;
		mrd_req = '0;
		strap_mode = 2'h1;
		hotplug_enable = 1'b0;
		cap_mode = 2'h1;
		cap_freq = 2'h3;
		apic_cfg_req = 1'b0;
		apic_smb_req = 1'b0;
		apic_mem_req = 1'b0;
		io_base = 8'h00;
		io_limit = 8'h00;
		hp_int = 1'b0;
		t_reset();
		t_mask();
		t_sticky();
		t_freq();
		t_apic();
		t_io();
		t_mrd();
		t_gpe();
		t_ce();
		complete_run();
	end
endmodule
